// [core/display_port.sv]
// Display-side serial register port with register file and start-up
//
// Notes on behaviour
// R1: Frame is direction flag, 7-bit address, byte.
// R2: Byte goes parallel on its eighth rising edge.
// R3: Select inactive clears shift register and counter.
// R4: Host holds select low for whole command.
// R5: Interrupted byte discarded; retaken after reselect.
// R6: Read returns addressed register byte on data.
// R7: Host raises select after read byte.
// R8: Sample on rising, change output on falling.
// R9: Host captures read bits on rising edges.
// R10: Host releases data by last command bit.
// R11: Registers 0 to 63 are readable.
// R12: Reset pin or soft command restores defaults.
// R13: Display starts tenth frame-sync fall, white first.
// R14: Data pin is shared in both directions.
// R15: Device drives data only for read byte.
`default_nettype none
module display_port #(
    parameter logic [7:0] CHIP_ID = 8'h5A // Value is arbitrary
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    trw_if.device                            link,
    output logic                             wrStrobe,
    output logic [5:0]                       wrAddr,
    output logic [trw_pkg::DATA_W-1:0]       wrData,
    output logic                             softReset,
    output logic                             displayOn,
    output logic                             whiteFrame
);
    localparam int PINS = 5;

    logic [PINS-1:0] pinRaw;
    logic [PINS-1:0] sync1_q;
    logic [PINS-1:0] sync2_q;
    logic [PINS-1:0] sync3_q;
    logic [PINS-1:0] filt_q;
    logic [PINS-1:0] filt_d;

    assign pinRaw = {link.frameSync, link.activeLowResetPin,
                     link.sdaLine, link.chipSelN, link.serClk};

    // A change counts once the second and third stages agree
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : gSample
            assign filt_d[g] = (sync2_q[g] == sync3_q[g]) ?
                               sync3_q[g] : filt_q[g];
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_q <= trw_pkg::PIN_IDLE;
            sync2_q <= trw_pkg::PIN_IDLE;
            sync3_q <= trw_pkg::PIN_IDLE;
            filt_q  <= trw_pkg::PIN_IDLE;
        end else begin
            sync1_q <= pinRaw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= filt_d;
        end
    end

    logic sclRise;
    logic sclFall;
    logic csIdle;
    logic sdaIn;
    logic pinResetLow;
    logic syncFall;

    assign sclRise     = filt_d[0] & ~filt_q[0];
    assign sclFall     = ~filt_d[0] & filt_q[0];
    assign csIdle      = filt_q[1];
    assign sdaIn       = filt_q[2];
    assign pinResetLow = ~filt_q[3];
    assign syncFall    = ~filt_d[4] & filt_q[4];

    // Serial engine and register file
    logic [4:0]                  bitCnt_q;
    logic [4:0]                  bitCnt_d;
    logic [7:0]                  shift_q;
    logic [7:0]                  shift_d;
    logic                        rdMode_q;
    logic                        rdMode_d;
    logic [6:0]                  addr_q;
    logic [6:0]                  addr_d;
    logic [7:0]                  out_q;
    logic [7:0]                  out_d;
    logic                        sdaOut_q;
    logic                        sdaOut_d;
    logic                        sdaOe_q;
    logic                        sdaOe_d;
    logic [7:0]                  regs_q [trw_pkg::REG_COUNT];
    logic [7:0]                  regs_d [trw_pkg::REG_COUNT];
    logic                        wrStrobe_q;
    logic                        wrStrobe_d;
    logic [5:0]                  wrAddr_q;
    logic [5:0]                  wrAddr_d;
    logic [7:0]                  wrData_q;
    logic [7:0]                  wrData_d;
    logic                        softReset_q;
    logic                        softReset_d;
    logic [6:0]                  cmdAddr;
    logic [7:0]                  dataByte;

    assign cmdAddr  = {shift_q[5:0], sdaIn};
    assign dataByte = {shift_q[6:0], sdaIn};

    function automatic logic [7:0] readByte(input logic [6:0] a,
                                            input logic [7:0] r);
        if (a > trw_pkg::READABLE_TOP) begin
            return trw_pkg::REG_ZERO;
        end
        if (a == trw_pkg::ID_ADDR) begin
            return CHIP_ID;
        end
        return r;
    endfunction

    always_comb begin
        bitCnt_d    = bitCnt_q;
        shift_d     = shift_q;
        rdMode_d    = rdMode_q;
        addr_d      = addr_q;
        out_d       = out_q;
        sdaOut_d    = sdaOut_q;
        sdaOe_d     = sdaOe_q;
        regs_d      = regs_q;
        wrStrobe_d  = 1'b0;
        wrAddr_d    = wrAddr_q;
        wrData_d    = wrData_q;
        softReset_d = 1'b0;
        if (csIdle || pinResetLow) begin
            bitCnt_d = 5'h00; // R3 R5
            shift_d  = 8'h00; // R3 R5
            sdaOe_d  = 1'b0; // R15
        end else begin
            if (sclRise && bitCnt_q < trw_pkg::FRAME_BITS) begin
                shift_d  = dataByte; // R8
                bitCnt_d = bitCnt_q + 5'h01;
                if (bitCnt_q == trw_pkg::CMD_BITS - 5'h01) begin
                    rdMode_d = shift_q[6]; // R1 R2
                    addr_d   = cmdAddr; // R1 R2
                    out_d    = readByte(cmdAddr,
                                        regs_q[cmdAddr[5:0]]); // R6 R11
                end
                if (bitCnt_q == trw_pkg::FRAME_BITS - 5'h01 &&
                    !rdMode_q) begin
                    if (addr_q == trw_pkg::SOFT_RESET_ADDR) begin
                        softReset_d = 1'b1; // R12
                    end else if (addr_q <= trw_pkg::READABLE_TOP &&
                                 addr_q != trw_pkg::ID_ADDR) begin
                        regs_d[addr_q[5:0]] = dataByte; // R2
                        wrStrobe_d          = 1'b1;
                        wrAddr_d            = addr_q[5:0];
                        wrData_d            = dataByte;
                    end
                end
            end
            if (sclFall && rdMode_q &&
                bitCnt_q >= trw_pkg::CMD_BITS &&
                bitCnt_q < trw_pkg::FRAME_BITS) begin
                sdaOe_d  = 1'b1; // R6 R14 R15
                sdaOut_d = out_q[7]; // R8
                out_d    = {out_q[6:0], 1'b0};
            end
            if (sclFall && bitCnt_q == trw_pkg::FRAME_BITS) begin
                sdaOe_d = 1'b0; // R15
            end
        end
        if (pinResetLow || softReset_d) begin
            for (int i = 0; i < trw_pkg::REG_COUNT; i++) begin
                regs_d[i] = trw_pkg::regDefault(i); // R12
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bitCnt_q    <= 5'h00;
            shift_q     <= 8'h00;
            rdMode_q    <= 1'b0;
            addr_q      <= 7'h00;
            out_q       <= 8'h00;
            sdaOut_q    <= 1'b1;
            sdaOe_q     <= 1'b0;
            wrStrobe_q  <= 1'b0;
            wrAddr_q    <= 6'h00;
            wrData_q    <= 8'h00;
            softReset_q <= 1'b0;
            for (int i = 0; i < trw_pkg::REG_COUNT; i++) begin
                regs_q[i] <= trw_pkg::regDefault(i);
            end
        end else begin
            bitCnt_q    <= bitCnt_d;
            shift_q     <= shift_d;
            rdMode_q    <= rdMode_d;
            addr_q      <= addr_d;
            out_q       <= out_d;
            sdaOut_q    <= sdaOut_d;
            sdaOe_q     <= sdaOe_d;
            wrStrobe_q  <= wrStrobe_d;
            wrAddr_q    <= wrAddr_d;
            wrData_q    <= wrData_d;
            softReset_q <= softReset_d;
            regs_q      <= regs_d;
        end
    end

    // Display start-up after the reset pin is released
    logic [3:0] edgeCnt_q;
    logic [3:0] edgeCnt_d;
    logic       dispOn_q;
    logic       dispOn_d;
    logic       white_q;
    logic       white_d;

    always_comb begin
        edgeCnt_d = edgeCnt_q;
        dispOn_d  = dispOn_q;
        white_d   = white_q;
        if (pinResetLow) begin
            edgeCnt_d = 4'h0;
            dispOn_d  = 1'b0;
            white_d   = 1'b0;
        end else if (syncFall) begin
            if (!dispOn_q) begin
                edgeCnt_d = edgeCnt_q + 4'h1;
                if (edgeCnt_q == trw_pkg::START_EDGES - 4'h1) begin
                    dispOn_d = 1'b1; // R13
                    white_d  = 1'b1; // R13
                end
            end else begin
                white_d = 1'b0; // R13
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            edgeCnt_q <= 4'h0;
            dispOn_q  <= 1'b0;
            white_q   <= 1'b0;
        end else begin
            edgeCnt_q <= edgeCnt_d;
            dispOn_q  <= dispOn_d;
            white_q   <= white_d;
        end
    end

    assign link.sdaDev   = sdaOut_q;
    assign link.sdaDevOe = sdaOe_q;
    assign wrStrobe      = wrStrobe_q;
    assign wrAddr        = wrAddr_q;
    assign wrData        = wrData_q;
    assign softReset     = softReset_q;
    assign displayOn     = dispOn_q;
    assign whiteFrame    = white_q;
endmodule
`default_nettype wire

// [shared/trw_pkg.sv]
// Shared constants for the three-wire configuration register port
`default_nettype none
package trw_pkg;
    localparam int CLK_NS        = 25;
    localparam int SCL_HALF_NS   = 250;
    localparam int CS_SETUP_NS   = 60;
    localparam int CS_HOLD_NS    = 70;
    localparam int CS_HIGH_NS    = 1000;
    localparam int RST_LOW_NS    = 1000;
    localparam int RST_DONE_NS   = 1000;
    localparam int SCL_HALF_CYC  = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_SETUP_CYC  = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_HOLD_CYC   = (CS_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_HIGH_CYC   = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_LOW_CYC   = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_DONE_CYC  = (RST_DONE_NS + CLK_NS - 1) / CLK_NS;

    localparam int ADDR_W        = 7;
    localparam int DATA_W        = 8;
    localparam int REG_COUNT     = 64;
    localparam logic [4:0] CMD_BITS   = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [6:0] READABLE_TOP    = 7'h3F;
    localparam logic [6:0] ID_ADDR         = 7'h00;
    localparam logic [6:0] SOFT_RESET_ADDR = 7'h7F;
    localparam logic [3:0] START_EDGES     = 4'hA;
    // Pin sampler idle levels: frame sync, reset pin, data, select, clock
    localparam logic [4:0] PIN_IDLE        = 5'h1F;

    localparam logic [7:0] REG1_RST = 8'h68;
    localparam logic [7:0] REG3_RST = 8'h04;
    localparam logic [7:0] REG4_RST = 8'h1D;
    localparam logic [7:0] REG5_RST = 8'h01;
    localparam logic [7:0] REG7_RST = 8'h20;
    localparam logic [7:0] REG_ZERO = 8'h00;

    function automatic logic [7:0] regDefault(input int unsigned idx);
        case (idx)
            1:       return REG1_RST;
            3:       return REG3_RST;
            4:       return REG4_RST;
            5:       return REG5_RST;
            7:       return REG7_RST;
            default: return REG_ZERO;
        endcase
    endfunction
endpackage
`default_nettype wire

// [shared/trw_if.sv]
// Three-wire link between host controller and display register port
`default_nettype none
interface trw_if;
    logic serClk;
    logic chipSelN;
    logic sdaHost;
    logic sdaHostOe;
    logic sdaDev;
    logic sdaDevOe;
    logic activeLowResetPin;
    logic frameSync;
    logic sdaLine;

    // Shared data wire with a pull-up when nobody drives it
    assign sdaLine = sdaDevOe ? sdaDev : (sdaHostOe ? sdaHost : 1'b1);

    modport device (
        input  serClk,
        input  chipSelN,
        input  sdaLine,
        input  activeLowResetPin,
        input  frameSync,
        output sdaDev,
        output sdaDevOe
    );
    modport host (
        output serClk,
        output chipSelN,
        output sdaHost,
        output sdaHostOe,
        output activeLowResetPin,
        output frameSync,
        input  sdaLine
    );
endinterface
`default_nettype wire

// [core/host_port.sv]
// Host-side controller that drives the three-wire register link
`default_nettype none
module host_port (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    trw_if.host                              link,
    input  wire logic                        start,
    input  wire logic                        readNotWrite,
    input  wire logic [trw_pkg::ADDR_W-1:0]  addr,
    input  wire logic [trw_pkg::DATA_W-1:0]  wdata,
    input  wire logic                        resetReq,
    input  wire logic                        frameSyncIn,
    output logic                             busy,
    output logic                             done,
    output logic [trw_pkg::DATA_W-1:0]       rdata
);
    typedef enum logic [7:0] {
        IDLE     = 8'h01,
        RST_LOW  = 8'h02,
        RST_WAIT = 8'h04,
        SETUP    = 8'h08,
        CLK_LOW  = 8'h10,
        CLK_HIGH = 8'h20,
        HOLD     = 8'h40,
        GAP      = 8'h80
    } state_t;

    logic [2:0] sdaSync_q;
    logic       sdaFilt_q;
    logic       sdaFilt_d;

    assign sdaFilt_d = (sdaSync_q[1] == sdaSync_q[2]) ?
                       sdaSync_q[2] : sdaFilt_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sdaSync_q <= 3'h7;
            sdaFilt_q <= 1'b1;
        end else begin
            sdaSync_q <= {sdaSync_q[1:0], link.sdaLine};
            sdaFilt_q <= sdaFilt_d;
        end
    end

    state_t      state_q;
    state_t      state_d;
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_d;
    logic [4:0]  bit_q;
    logic [4:0]  bit_d;
    logic [15:0] tx_q;
    logic [15:0] tx_d;
    logic [7:0]  rx_q;
    logic [7:0]  rx_d;
    logic        rd_q;
    logic        rd_d;
    logic        scl_q;
    logic        scl_d;
    logic        cs_q;
    logic        cs_d;
    logic        sdaO_q;
    logic        sdaO_d;
    logic        sdaOe_q;
    logic        sdaOe_d;
    logic        rstPin_q;
    logic        rstPin_d;
    logic        fsync_q;
    logic        busy_q;
    logic        busy_d;
    logic        done_q;
    logic        done_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    function automatic logic hit(input logic [5:0] c, input int n);
        return c == 6'(n - 1);
    endfunction

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q + 6'h01;
        bit_d    = bit_q;
        tx_d     = tx_q;
        rx_d     = rx_q;
        rd_d     = rd_q;
        scl_d    = scl_q;
        cs_d     = cs_q;
        sdaO_d   = sdaO_q;
        sdaOe_d  = sdaOe_q;
        rstPin_d = rstPin_q;
        busy_d   = busy_q;
        done_d   = 1'b0;
        rdata_d  = rdata_q;
        unique case (state_q)
            IDLE: begin
                cnt_d = 6'h00;
                if (resetReq) begin
                    rstPin_d = 1'b0;
                    busy_d   = 1'b1;
                    state_d  = RST_LOW;
                end else if (start) begin
                    tx_d    = {readNotWrite, addr, wdata}; // R1
                    rd_d    = readNotWrite;
                    cs_d    = 1'b0;
                    busy_d  = 1'b1;
                    state_d = SETUP;
                end
            end
            RST_LOW: begin
                if (hit(cnt_q, trw_pkg::RST_LOW_CYC)) begin
                    rstPin_d = 1'b1;
                    cnt_d    = 6'h00;
                    state_d  = RST_WAIT;
                end
            end
            RST_WAIT: begin
                if (hit(cnt_q, trw_pkg::RST_DONE_CYC)) begin
                    busy_d  = 1'b0;
                    done_d  = 1'b1;
                    state_d = IDLE;
                end
            end
            SETUP: begin
                if (hit(cnt_q, trw_pkg::CS_SETUP_CYC)) begin
                    cnt_d   = 6'h00;
                    bit_d   = 5'h00;
                    scl_d   = 1'b0;
                    sdaOe_d = 1'b1; // R14
                    sdaO_d  = tx_q[15];
                    state_d = CLK_LOW;
                end
            end
            CLK_LOW: begin
                if (hit(cnt_q, trw_pkg::SCL_HALF_CYC)) begin
                    cnt_d   = 6'h00;
                    scl_d   = 1'b1;
                    tx_d    = {tx_q[14:0], 1'b0};
                    state_d = CLK_HIGH;
                    if (rd_q && bit_q == trw_pkg::CMD_BITS - 5'h01) begin
                        sdaOe_d = 1'b0; // R10
                    end
                    if (rd_q && bit_q >= trw_pkg::CMD_BITS) begin
                        rx_d = {rx_q[6:0], sdaFilt_q}; // R9
                    end
                end
            end
            CLK_HIGH: begin
                if (hit(cnt_q, trw_pkg::SCL_HALF_CYC)) begin
                    cnt_d = 6'h00;
                    if (bit_q == trw_pkg::FRAME_BITS - 5'h01) begin
                        sdaOe_d = 1'b0;
                        state_d = HOLD;
                    end else begin
                        bit_d   = bit_q + 5'h01;
                        scl_d   = 1'b0;
                        sdaO_d  = tx_q[15];
                        state_d = CLK_LOW;
                    end
                end
            end
            HOLD: begin
                if (hit(cnt_q, trw_pkg::CS_HOLD_CYC)) begin
                    cnt_d   = 6'h00;
                    cs_d    = 1'b1; // R4 R7
                    rdata_d = rx_q;
                    state_d = GAP;
                end
            end
            GAP: begin
                if (hit(cnt_q, trw_pkg::CS_HIGH_CYC)) begin
                    busy_d  = 1'b0;
                    done_d  = 1'b1;
                    state_d = IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q  <= IDLE;
            cnt_q    <= 6'h00;
            bit_q    <= 5'h00;
            tx_q     <= 16'h0000;
            rx_q     <= 8'h00;
            rd_q     <= 1'b0;
            scl_q    <= 1'b1;
            cs_q     <= 1'b1;
            sdaO_q   <= 1'b1;
            sdaOe_q  <= 1'b0;
            rstPin_q <= 1'b1;
            fsync_q  <= 1'b1;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            rdata_q  <= 8'h00;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            bit_q    <= bit_d;
            tx_q     <= tx_d;
            rx_q     <= rx_d;
            rd_q     <= rd_d;
            scl_q    <= scl_d;
            cs_q     <= cs_d;
            sdaO_q   <= sdaO_d;
            sdaOe_q  <= sdaOe_d;
            rstPin_q <= rstPin_d;
            fsync_q  <= frameSyncIn;
            busy_q   <= busy_d;
            done_q   <= done_d;
            rdata_q  <= rdata_d;
        end
    end

    assign link.serClk            = scl_q;
    assign link.chipSelN          = cs_q;
    assign link.sdaHost           = sdaO_q;
    assign link.sdaHostOe         = sdaOe_q;
    assign link.activeLowResetPin = rstPin_q;
    assign link.frameSync         = fsync_q;
    assign busy                   = busy_q;
    assign done                   = done_q;
    assign rdata                  = rdata_q;
endmodule
`default_nettype wire

// [sim/trw_properties.sv]
// Protocol checks on the three-wire link between host and display ends
`default_nettype none
module trw_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serClk,
    input wire logic chipSelN,
    input wire logic sdaHostOe,
    input wire logic sdaDev,
    input wire logic sdaDevOe,
    input wire logic activeLowResetPin,
    input wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       clkQ, clkD, rdQ, rdD;
    logic [4:0] cntQ, cntD;

    // Rising serial clocks and direction flag of the open frame
    always_comb begin
        clkD = serClk;
        cntD = cntQ;
        rdD = rdQ;
        if (chipSelN) begin
            cntD = 5'h00;
        end else if (serClk && !clkQ) begin
            cntD = cntQ + 5'h01;
            if (cntQ == 5'h00) begin
                rdD = sdaLine;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clkQ <= 1'b1;
            cntQ <= 5'h00;
            rdQ <= 1'b0;
        end else begin
            clkQ <= clkD;
            cntQ <= cntD;
            rdQ <= rdD;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence readTurn;
        $fell(serClk) && !chipSelN && cntQ == 5'h08 && rdQ;
    endsequence
    sequence frameEnd;
        $rose(chipSelN);
    endsequence

    a_frame_sixteen: assert property (frameEnd |-> cntQ == 5'h10)
        else $error("frame did not carry sixteen clocks");
    a_read_drive: assert property (readTurn |-> ##[1:6] sdaDevOe)
        else $error("read byte not driven");
    a_host_release: assert property (readTurn |-> !sdaHostOe)
        else $error("host still drives after read command");
    a_single_driver: assert property (!(sdaDevOe && sdaHostOe))
        else $error("both ends drive data");
    a_dev_release: assert property (frameEnd |-> ##[1:6] !sdaDevOe)
        else $error("device drives after select rise");
    a_write_quiet: assert property (
        !chipSelN && !rdQ && cntQ != 5'h00 |-> !sdaDevOe)
        else $error("device drives during write");
    a_pin_quiet: assert property (
        !activeLowResetPin [*6] |-> !sdaDevOe)
        else $error("device drives under reset pin");
    a_change_fall: assert property (sdaDevOe && $past(sdaDevOe)
        && !chipSelN && $changed(sdaDev) |-> !serClk)
        else $error("device data moved in clock high phase");
    a_clock_in_frame: assert property ($fell(serClk) |-> !chipSelN)
        else $error("serial clock toggled without select");
endmodule
`default_nettype wire

// [sim/three_wire_register_port_tb_top.sv]
// Self-checking bench joining host and display ends of the link
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_errors++; $display("unexpected %s: expected %h seen %h", n, e, g); \
    end end
module three_wire_register_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic rw; logic [6:0] a; logic [7:0] d; logic [7:0] e;
    } row_t;
    localparam logic [7:0] ID = 8'h3C; // Value is arbitrary
    // Reads expect data in e; writes expect a strobe when e is 1
    localparam row_t ROWS [11] = '{
        '{1'b1, 7'h00, 8'h00, ID}, '{1'b1, 7'h01, 8'h00, 8'h68},
        '{1'b1, 7'h07, 8'h00, 8'h20}, '{1'b0, 7'h03, 8'hA5, 8'h01},
        '{1'b1, 7'h03, 8'h00, 8'hA5}, '{1'b0, 7'h3F, 8'h5A, 8'h01},
        '{1'b1, 7'h3F, 8'h00, 8'h5A}, '{1'b0, 7'h00, 8'h77, 8'h00},
        '{1'b1, 7'h00, 8'h00, ID}, '{1'b1, 7'h40, 8'h00, 8'h00},
        '{1'b0, 7'h41, 8'h11, 8'h00}};
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       start = 1'b0;
    logic       readNotWrite = 1'b0;
    logic       resetReq = 1'b0;
    logic       frameSyncIn = 1'b1;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic       busy, done, wrStrobe, softReset, displayOn, whiteFrame;
    logic [7:0] rdata, wrData, wrData2;
    logic [5:0] wrAddr, wrAddr2;
    int         n_errors = 0, cmp_count = 0, nStb = 0, nSoft = 0, expStb = 0;

    trw_if lnk();
    trw_if lnk2();
    host_port u_host_port (.ref_clk, .rst, .link(lnk), .start,
        .readNotWrite, .addr, .wdata, .resetReq, .frameSyncIn, .busy,
        .done, .rdata);
    display_port #(.CHIP_ID(ID)) u_display_port (.ref_clk, .rst,
        .link(lnk), .wrStrobe, .wrAddr, .wrData, .softReset, .displayOn,
        .whiteFrame);
    display_port #(.CHIP_ID(ID)) u_display_port_b (.ref_clk, .rst,
        .link(lnk2), .wrStrobe(), .wrAddr(wrAddr2), .wrData(wrData2),
        .softReset(), .displayOn(), .whiteFrame());
    trw_properties u_trw_properties (.ref_clk, .rst,
        .serClk(lnk.serClk), .chipSelN(lnk.chipSelN),
        .sdaHostOe(lnk.sdaHostOe), .sdaDev(lnk.sdaDev),
        .sdaDevOe(lnk.sdaDevOe), .sdaLine(lnk.sdaLine),
        .activeLowResetPin(lnk.activeLowResetPin));

    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (wrStrobe === 1'b1) nStb++;
        if (softReset === 1'b1) nSoft++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic xfer(input logic rw, input logic [6:0] a,
                        input logic [7:0] d, input logic rq);
        readNotWrite = rw;
        addr = a;
        wdata = d;
        start = !rq;
        resetReq = rq;
        tick(1);
        start = 1'b0;
        resetReq = 1'b0;
        `CHK("busy", 1'b1, busy)
        for (int i = 0; i < 1000 && done !== 1'b1; i++) tick(1);
        `CHK("done", 1'b1, done)
        `CHK("select", 1'b1, lnk.chipSelN)
    endtask

    // Bench-made link clock, 200 ns period; n bits then select rises
    task automatic bang(input logic [15:0] bits, input int n);
        lnk2.chipSelN = 1'b0;
        lnk2.sdaHostOe = 1'b1;
        tick(4);
        for (int i = 15; i > 15 - n; i--) begin
            lnk2.serClk = 1'b0;
            lnk2.sdaHost = bits[i];
            tick(4);
            lnk2.serClk = 1'b1;
            tick(4);
        end
        lnk2.chipSelN = 1'b1;
        lnk2.sdaHostOe = 1'b0;
        tick(40);
    endtask

    task automatic report_and_stop;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        report_and_stop;
    end

    initial begin
        lnk2.serClk = 1'b1;
        lnk2.chipSelN = 1'b1;
        lnk2.sdaHost = 1'b1;
        lnk2.sdaHostOe = 1'b0;
        lnk2.activeLowResetPin = 1'b1;
        lnk2.frameSync = 1'b1;
        tick(16);
        rst = 1'b0;
        tick(2);
        `CHK("idle data", 1'b1, lnk.sdaLine)
        `CHK("idle clock", 1'b1, lnk.serClk)
        foreach (ROWS[i]) begin
            xfer(ROWS[i].rw, ROWS[i].a, ROWS[i].d, 1'b0);
            if (ROWS[i].rw) `CHK("rdata", ROWS[i].e, rdata)
            else begin
                expStb += ROWS[i].e[0];
                `CHK("strobes", expStb, nStb)
                if (ROWS[i].e[0]) begin
                    `CHK("wrData", ROWS[i].d, wrData)
                    `CHK("wrAddr", ROWS[i].a[5:0], wrAddr)
                end
            end
        end
        xfer(1'b0, 7'h03, 8'h55, 1'b0);
        xfer(1'b0, 7'h7F, 8'h00, 1'b0);
        `CHK("softReset", 1, nSoft)
        xfer(1'b1, 7'h03, 8'h00, 1'b0);
        `CHK("rdata", 8'h04, rdata)
        xfer(1'b0, 7'h05, 8'h99, 1'b0);
        xfer(1'b0, 7'h00, 8'h00, 1'b1);
        xfer(1'b1, 7'h05, 8'h00, 1'b0);
        `CHK("rdata", 8'h01, rdata)
        for (int k = 1; k <= 11; k++) begin
            frameSyncIn = 1'b0;
            tick(8);
            frameSyncIn = 1'b1;
            tick(8);
            `CHK("displayOn", k >= 10, displayOn)
            `CHK("whiteFrame", k == 10, whiteFrame)
        end
        bang({1'b0, 7'h03, 8'hC3}, 5);
        bang({1'b0, 7'h03, 8'h3C}, 12);
        bang({1'b0, 7'h03, 8'hC3}, 16);
        `CHK("wrData", 8'hC3, wrData2)
        `CHK("wrAddr", 6'h03, wrAddr2)
        report_and_stop;
    end
endmodule
`default_nettype wire
